// ---- verilog/lh_pkg.sv ----
package lh_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ = 25;
   localparam int PO_DELAY_US = 1000;
   localparam int PO_DELAY_CYC = PO_DELAY_US * CLK_MHZ;
   localparam int T_REF_C = 25;

   // ************************************************************
   // register map (byte offsets)
   // ************************************************************
   localparam logic [7:0] OFS_PARAM = 8'h00;
   localparam logic [7:0] OFS_INJ = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_DUTY = 8'h28;

   // ************************************************************
   // parameter memory layout
   // ************************************************************
   localparam int N_WORDS = 8;
   localparam int DATA_W = 16;
   localparam int CW_W = 22;
   localparam int W_LIN = 0;
   localparam int W_QCOLD = 1;
   localparam int W_QHOT = 2;
   localparam int W_OFFS = 3;
   localparam int W_GAIN = 4;
   localparam int W_QUIES = 5;
   localparam int W_CLHI = 6;
   localparam int W_CLLO = 7;
   localparam int LIN_HOT_LSB = 8;
   localparam int POL_BIT = 8;
   localparam int INJ_WORD_LSB = 24;
   localparam logic [15:0] RST_WORD [N_WORDS] = '{
      16'h4040, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h07FF, 16'h0000};

   // ************************************************************
   // arithmetic scaling
   // ************************************************************
   localparam int TC1_BIAS = 64;
   localparam int TC1_ALIGN = 256;
   localparam int TC_SHIFT = 24;
   localparam int OFF_SHIFT = 4;
   localparam int GAIN_SHIFT = 9;
   localparam int DUTY_MAX = 4095;
   localparam logic [11:0] DUTY_FULL = 12'hFFF;
   localparam logic [11:0] DUTY_ZERO = 12'h000;
   localparam logic [11:0] CLHI_BASE = 12'h800;

   // ************************************************************
   // status bits
   // ************************************************************
   localparam int ST_UV = 0;
   localparam int ST_PO = 1;
   localparam int ST_OV = 2;
   localparam int ST_MEMF = 3;
   localparam int ST_CORR = 4;

   typedef enum logic [1:0] {
      SUP_NORMAL = 2'b00,
      SUP_UV = 2'b01,
      SUP_PO_WAIT = 2'b10
   } lh_supply_e;

   // secded: hamming positions 1..21, overall parity at bit 0
   function automatic logic [CW_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
      logic [CW_W-1:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p < CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p] = d[k];
            k++;
         end
      end
      for (int i = 0; i < 5; i++) begin
         for (int p = 1; p < CW_W; p++) begin
            if (((p >> i) & 1) == 1 && (p & (p - 1)) != 0) begin
               c[1 << i] = c[1 << i] ^ c[p];
            end
         end
      end
      c[0] = ^c[CW_W-1:1];
      return c;
   endfunction
endpackage

// ---- verilog/lh_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module lh_sync #(
   parameter int W = 1
)(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_chk
      $error("lh_sync width must be at least one");
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/lh_ecc_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
module lh_ecc_dec (
   // stored codeword
   input wire logic [lh_pkg::CW_W-1:0] codeword,
   // decoded result
   output logic [lh_pkg::DATA_W-1:0] data,
   output logic corrected,
   output logic uncorrectable
);
   logic [4:0] syn;
   logic par;
   logic [lh_pkg::CW_W-1:0] fixed;

   always_comb begin
      int k;
      k = 0;
      syn = '0;
      for (int i = 0; i < 5; i++) begin
         for (int p = 1; p < lh_pkg::CW_W; p++) begin
            if (((p >> i) & 1) == 1) begin
               syn[i] = syn[i] ^ codeword[p];
            end
         end
      end
      par = ^codeword;
      fixed = codeword;
      // single error: overall parity odd, flip the addressed bit
      if (par && syn != 5'h00 && int'(syn) < lh_pkg::CW_W) begin
         fixed[syn] = ~codeword[syn];
      end
      corrected = par;
      // even parity with nonzero syndrome means two bits flipped
      uncorrectable = (!par && syn != 5'h00) ||
                      (par && int'(syn) >= lh_pkg::CW_W);
      data = '0;
      for (int p = 1; p < lh_pkg::CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            data[k] = fixed[p];
            k++;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/lh_output_path.sv ----
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lh_output_path #(
   parameter int PO_DELAY_CYC = lh_pkg::PO_DELAY_CYC
)(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter samples, same clock domain
   input wire logic adc_valid,
   input wire logic [15:0] adc_sample,
   input wire logic [8:0] temp_c,
   // supply comparators, asynchronous
   input wire logic vcc_below_uv_low,
   input wire logic vcc_above_uv_high,
   input wire logic vcc_above_ov_high,
   input wire logic vcc_below_ov_low,
   // duty cycle to the current modulator
   output logic [11:0] duty_cycle,
   output logic duty_valid
);
   // ************************************************************
   // declarations
   // ************************************************************
   logic [lh_pkg::CW_W-1:0] mem [lh_pkg::N_WORDS];
   logic [lh_pkg::DATA_W-1:0] word [lh_pkg::N_WORDS];
   logic [lh_pkg::N_WORDS-1:0] corr;
   logic [lh_pkg::N_WORDS-1:0] dbl;
   logic [3:0] sup_s;
   logic uv_low;
   logic uv_high;
   logic ov_high;
   logic ov_low;
   lh_pkg::lh_supply_e sup;
   lh_pkg::lh_supply_e next_sup;
   logic [31:0] po_cnt;
   logic ov_active;
   logic mem_fault;
   logic corr_seen;
   logic is_param;
   logic is_inj;
   logic is_status;
   logic is_duty;
   logic hit;
   logic wr_en;
   logic [2:0] word_idx;
   logic [2:0] inj_idx;
   logic [7:0] gain_lin_coef_cold;
   logic [7:0] gain_lin_coef_hot;
   logic [8:0] gain_quad_coef_cold;
   logic [8:0] gain_quad_coef_hot;
   logic [7:0] offset_temp_coef;
   logic invert;
   logic [11:0] gain_trim_code;
   logic [11:0] quiescent_trim_code;
   logic [10:0] clamp_high_code;
   logic [10:0] clamp_low_code;
   logic [12:0] gain_multiplier;
   logic signed [11:0] quiescent_fine_value;
   logic signed [9:0] next_dt;
   logic signed [8:0] lin_sel;
   logic signed [8:0] quad_sel;
   logic signed [29:0] next_f;
   logic signed [17:0] next_off;
   logic s1_valid;
   logic signed [15:0] s1_y;
   logic signed [29:0] s1_f;
   logic signed [17:0] offset_drift_term;
   logic s2_valid;
   logic signed [23:0] compensated_sample;
   logic s3_valid;
   logic signed [31:0] preclamp_output;
   logic [11:0] next_normal;
   logic [11:0] normal_duty;
   logic [11:0] clamp_lo;
   logic [11:0] clamp_hi;

   if (PO_DELAY_CYC < 1) begin : g_chk
      $error("power-on delay must be at least one cycle");
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   // zero wait states: every access phase completes in its first cycle
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign word_idx = paddr[4:2];
   assign inj_idx = pwdata[lh_pkg::INJ_WORD_LSB +: 3];
   assign is_param = paddr[1:0] == 2'b00 && paddr < lh_pkg::OFS_INJ;
   assign is_inj = paddr == lh_pkg::OFS_INJ;
   assign is_status = paddr == lh_pkg::OFS_STATUS;
   assign is_duty = paddr == lh_pkg::OFS_DUTY;
   assign hit = is_param || is_inj || is_status || is_duty;
   assign pslverr = psel && penable && !hit;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata <= 32'h00000000;
         if (is_param) begin
            prdata <= {16'h0000, word[word_idx]};
         end else if (is_status) begin
            prdata[lh_pkg::ST_UV] <= sup == lh_pkg::SUP_UV;
            prdata[lh_pkg::ST_PO] <= sup == lh_pkg::SUP_PO_WAIT;
            prdata[lh_pkg::ST_OV] <= ov_active;
            prdata[lh_pkg::ST_MEMF] <= mem_fault;
            prdata[lh_pkg::ST_CORR] <= corr_seen;
         end else if (is_duty) begin
            prdata <= {20'h00000, duty_cycle};
         end
      end
   end

   // ************************************************************
   // parameter memory with check bits
   // ************************************************************
   // writes store a fresh codeword; the injection register flips stored
   // bits so software can exercise correction and the fault override
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < lh_pkg::N_WORDS; i++) begin
            mem[i] <= lh_pkg::ecc_encode(lh_pkg::RST_WORD[i]);
         end
      end else if (wr_en && is_param) begin
         mem[word_idx] <= lh_pkg::ecc_encode(pwdata[15:0]);
      end else if (wr_en && is_inj) begin
         mem[inj_idx] <= mem[inj_idx] ^ pwdata[lh_pkg::CW_W-1:0];
      end
   end

   for (genvar g = 0; g < lh_pkg::N_WORDS; g++) begin : g_dec
      lh_ecc_dec u_dec (
         .codeword(mem[g]),
         .data(word[g]),
         .corrected(corr[g]),
         .uncorrectable(dbl[g])
      );
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mem_fault <= 1'b0;
      end else begin
         mem_fault <= |dbl;
      end
   end

   // sticky, cleared by writing one; a new correction wins over the clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         corr_seen <= 1'b0;
      end else if (|corr) begin
         corr_seen <= 1'b1;
      end else if (wr_en && is_status && pwdata[lh_pkg::ST_CORR]) begin
         corr_seen <= 1'b0;
      end
   end

   // ************************************************************
   // parameter fields
   // ************************************************************
   assign gain_lin_coef_cold = word[lh_pkg::W_LIN][7:0];
   assign gain_lin_coef_hot = word[lh_pkg::W_LIN][lh_pkg::LIN_HOT_LSB +: 8];
   assign gain_quad_coef_cold = word[lh_pkg::W_QCOLD][8:0];
   assign gain_quad_coef_hot = word[lh_pkg::W_QHOT][8:0];
   assign offset_temp_coef = word[lh_pkg::W_OFFS][7:0];
   assign invert = word[lh_pkg::W_OFFS][lh_pkg::POL_BIT];
   assign gain_trim_code = word[lh_pkg::W_GAIN][11:0];
   assign quiescent_trim_code = word[lh_pkg::W_QUIES][11:0];
   assign clamp_high_code = word[lh_pkg::W_CLHI][10:0];
   assign clamp_low_code = word[lh_pkg::W_CLLO][10:0];
   // code rotated by half scale: 0 -> 4.0, 2047 -> ~8.0, 2048 -> 0.0
   assign gain_multiplier = {1'b0, ~gain_trim_code[11],
                             gain_trim_code[10:0]};
   assign quiescent_fine_value = $signed(quiescent_trim_code);
   // low limit 0..2047, high limit 2048..4095 of a 4096 span
   assign clamp_lo = {1'b0, clamp_low_code};
   assign clamp_hi = lh_pkg::CLHI_BASE + {1'b0, clamp_high_code};

   // ************************************************************
   // stage 1: temperature terms
   // ************************************************************
   always_comb begin
      next_dt = 10'(int'($signed(temp_c)) - lh_pkg::T_REF_C);
      // above the reference uses the hot pair, below it the cold pair
      if (next_dt > 10'sd0) begin
         lin_sel = 9'(int'({1'b0, gain_lin_coef_hot}) - lh_pkg::TC1_BIAS);
         quad_sel = $signed(gain_quad_coef_hot);
      end else begin
         lin_sel = 9'(int'({1'b0, gain_lin_coef_cold}) - lh_pkg::TC1_BIAS);
         quad_sel = $signed(gain_quad_coef_cold);
      end
      // sensitivity factor in units of 2^-24
      next_f = 30'(int'(lin_sel) * int'(next_dt) * lh_pkg::TC1_ALIGN +
                   int'(quad_sel) * int'(next_dt) * int'(next_dt));
      next_off = 18'(int'($signed(offset_temp_coef)) *
                     int'(next_dt));
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_valid <= 1'b0;
         s1_y <= 16'sh0000;
         s1_f <= 30'sh00000000;
         offset_drift_term <= 18'sh00000;
      end else begin
         s1_valid <= adc_valid;
         if (adc_valid) begin
            s1_y <= $signed(adc_sample);
            s1_f <= next_f;
            offset_drift_term <= next_off;
         end
      end
   end

   // ************************************************************
   // stage 2: compensated sample
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s2_valid <= 1'b0;
         compensated_sample <= 24'sh000000;
      end else begin
         s2_valid <= s1_valid;
         if (s1_valid) begin
            compensated_sample <= 24'(longint'(s1_y) +
               ((longint'(s1_y) * longint'(s1_f)) >>> lh_pkg::TC_SHIFT) +
               (longint'(offset_drift_term) >>>
                lh_pkg::OFF_SHIFT));
         end
      end
   end

   // ************************************************************
   // stage 3: gain and fine offset
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s3_valid <= 1'b0;
         preclamp_output <= 32'sh00000000;
      end else begin
         s3_valid <= s2_valid;
         if (s2_valid) begin
            preclamp_output <= 32'(
               ((longint'(gain_multiplier) * longint'(compensated_sample))
                >>> lh_pkg::GAIN_SHIFT) +
               longint'(quiescent_fine_value));
         end
      end
   end

   // ************************************************************
   // stage 4: range, polarity and clamps
   // ************************************************************
   always_comb begin
      // limit to the span first so inversion stays inside it
      if (preclamp_output < 32'sh00000000) begin
         next_normal = lh_pkg::DUTY_ZERO;
      end else if (preclamp_output > 32'(lh_pkg::DUTY_MAX)) begin
         next_normal = lh_pkg::DUTY_FULL;
      end else begin
         next_normal = preclamp_output[11:0];
      end
      if (invert) begin
         next_normal = lh_pkg::DUTY_FULL - next_normal;
      end
      if (next_normal < clamp_lo) begin
         next_normal = clamp_lo;
      end else if (next_normal > clamp_hi) begin
         next_normal = clamp_hi;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         normal_duty <= lh_pkg::DUTY_ZERO;
      end else if (s3_valid) begin
         normal_duty <= next_normal;
      end
   end

   // ************************************************************
   // supply supervision
   // ************************************************************
   lh_sync #(
      .W(4)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .async_in({vcc_below_ov_low, vcc_above_ov_high,
                 vcc_above_uv_high, vcc_below_uv_low}),
      .sync_out(sup_s)
   );
   assign uv_low = sup_s[0];
   assign uv_high = sup_s[1];
   assign ov_high = sup_s[2];
   assign ov_low = sup_s[3];

   always_comb begin
      next_sup = sup;
      case (sup)
         lh_pkg::SUP_NORMAL: begin
            if (uv_low) begin
               next_sup = lh_pkg::SUP_UV;
            end
         end
         lh_pkg::SUP_UV: begin
            if (uv_high) begin
               next_sup = lh_pkg::SUP_PO_WAIT;
            end
         end
         lh_pkg::SUP_PO_WAIT: begin
            if (uv_low) begin
               next_sup = lh_pkg::SUP_UV;
            end else if (po_cnt == 32'(PO_DELAY_CYC - 1)) begin
               next_sup = lh_pkg::SUP_NORMAL;
            end
         end
         default: begin
            next_sup = lh_pkg::SUP_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sup <= lh_pkg::SUP_NORMAL;
      end else begin
         sup <= next_sup;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         po_cnt <= 32'h00000000;
      end else if (sup == lh_pkg::SUP_PO_WAIT && next_sup == sup) begin
         po_cnt <= po_cnt + 32'h00000001;
      end else begin
         po_cnt <= 32'h00000000;
      end
   end

   // hysteresis: set above the upper level, released below the lower one
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ov_active <= 1'b0;
      end else if (ov_high) begin
         ov_active <= 1'b1;
      end else if (ov_low) begin
         ov_active <= 1'b0;
      end
   end

   // ************************************************************
   // duty output with overrides
   // ************************************************************
   // forced levels skip the clamps, so a host can tell them apart from programmed
   // output only when clamp_lo is above 0 and clamp_hi below 4095
   always_ff @(posedge clk) begin
      if (!nrst) begin
         duty_cycle <= lh_pkg::DUTY_ZERO;
         duty_valid <= 1'b0;
      end else begin
         duty_valid <= s3_valid;
         if (mem_fault) begin
            duty_cycle <= lh_pkg::DUTY_ZERO;
         end else if (ov_active) begin
            duty_cycle <= lh_pkg::DUTY_ZERO;
         end else if (sup != lh_pkg::SUP_NORMAL) begin
            duty_cycle <= lh_pkg::DUTY_FULL;
         end else begin
            duty_cycle <= s3_valid ? next_normal : normal_duty;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/lh_sync_unused_placeholder_never.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verification/lh_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lh_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // duty cycle seen on the current loop
   input wire logic [11:0] duty_cycle,
   input wire logic duty_valid,
   // last decoded reading
   output logic [11:0] last_duty,
   output logic [15:0] frames
);
   // ************************************************************
   // frame capture
   // ************************************************************
   // only flagged frames count; a forced fault level on a sample cycle is flagged and counts too
   always_ff @(posedge clk) begin
      if (!nrst) begin
         last_duty <= 12'h000;
         frames <= 16'h0000;
      end else if (duty_valid) begin
         last_duty <= duty_cycle;
         frames <= frames + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ---- verification/lh_output_path_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module lh_output_path_chk #(
   parameter int PO_DELAY_CYC = 20
)(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // samples and supply
   input wire logic adc_valid,
   input wire logic [15:0] adc_sample,
   input wire logic [8:0] temp_c,
   input wire logic vcc_below_uv_low,
   input wire logic vcc_above_uv_high,
   input wire logic vcc_above_ov_high,
   input wire logic vcc_below_ov_low,
   // output
   input wire logic [11:0] duty_cycle,
   input wire logic duty_valid
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic inj_wr;
   assign inj_wr = psel && penable && pwrite && paddr == lh_pkg::OFS_INJ;
   ov_zero_a: assert property (
      vcc_above_ov_high [*6] |-> duty_cycle == 12'h000)
      else $error("duty not zero in overvoltage");
   uv_full_a: assert property (
      (vcc_below_uv_low && vcc_below_ov_low) [*6] |-> duty_cycle == 12'hFFF)
      else $error("duty not full in undervoltage");
   ov_over_uv_a: assert property (
      (vcc_above_ov_high && vcc_below_uv_low) [*6] |-> duty_cycle == 12'h000)
      else $error("undervoltage level won over overvoltage");
   memf_zero_a: assert property (
      inj_wr && $countones(pwdata[21:0]) == 2 |-> ##3 duty_cycle == 12'h000)
      else $error("double memory error did not force zero");
   valid_lat_a: assert property (
      duty_valid |-> $past(adc_valid, 4))
      else $error("result without a sample four cycles before");
   po_hold_a: assert property (
      $rose(vcc_above_uv_high) && vcc_below_ov_low && duty_cycle == 12'hFFF
      |-> ##1 (duty_cycle == 12'hFFF) [*8])
      else $error("power-on wait ended too early");
   single_fix_a: assert property (
      inj_wr && $countones(pwdata[21:0]) == 1 && duty_cycle != 12'h000
      |-> ##2 duty_cycle != 12'h000)
      else $error("single memory error changed the output");
   ov_hold_a: assert property (
      vcc_above_ov_high ##1 !vcc_below_ov_low [*7] |-> duty_cycle == 12'h000)
      else $error("overvoltage left before lower threshold");
   cover property (duty_valid);
   cover property (vcc_below_uv_low [*6]);
   cover property (vcc_above_ov_high ##1 !vcc_below_ov_low [*7]);
endmodule
bind lh_output_path lh_output_path_chk #(.PO_DELAY_CYC(PO_DELAY_CYC))
   lh_output_path_chk_i (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .adc_valid(adc_valid), .adc_sample(adc_sample), .temp_c(temp_c),
   .vcc_below_uv_low(vcc_below_uv_low), .vcc_above_uv_high(vcc_above_uv_high),
   .vcc_above_ov_high(vcc_above_ov_high), .vcc_below_ov_low(vcc_below_ov_low),
   .duty_cycle(duty_cycle), .duty_valid(duty_valid));
`default_nettype wire

// ---- verification/lh_output_path_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module lh_output_path_test;
   // ************************************************************
   // signals
   // ************************************************************
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic adc_valid, duty_valid, uv_lo, uv_hi, ov_hi, ov_lo;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adc_sample, host_frames;
   logic [8:0] temp_c;
   logic [11:0] duty_cycle, host_duty;
   logic [15:0] p [8];
   int num_errors, samples_checked;
   int ys[3] = '{-300, 100, 900};
   int ts[6] = '{85, -35, 150, -40, 26, 24};
   logic [7:0] ca[10] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
      8'h14, 8'h14, 8'h0C, 8'h18, 8'h1C};
   logic [31:0] cd[10] = '{32'h7FF, 32'h800, 32'h400, 32'hC00, 32'h0,
      32'h3E8, 32'hC18, 32'h150, 32'h0, 32'h64};
   // short power-on wait keeps the run brief
   lh_output_path #(.PO_DELAY_CYC(20)) lh_output_path_i (.clk(clk),
      .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .adc_valid(adc_valid), .adc_sample(adc_sample),
      .temp_c(temp_c), .vcc_below_uv_low(uv_lo), .vcc_above_uv_high(uv_hi),
      .vcc_above_ov_high(ov_hi), .vcc_below_ov_low(ov_lo),
      .duty_cycle(duty_cycle), .duty_valid(duty_valid));
   lh_host_model lh_host_model_i (.clk(clk), .nrst(nrst),
      .duty_cycle(duty_cycle), .duty_valid(duty_valid),
      .last_duty(host_duty), .frames(host_frames));
   // ************************************************************
   // tasks
   // ************************************************************
   function automatic logic [11:0] mdl(input longint y, input longint t);
      longint dt, c1, c2, f, v;
      dt = t - 25;
      c1 = (dt > 0) ? p[0][15:8] : p[0][7:0];
      c1 = c1 - 64;
      c2 = $signed(p[(dt > 0) ? 2 : 1][8:0]);
      f = c1 * dt * 256 + c2 * dt * dt;
      v = y + ((y * f) >>> 24) + (($signed(p[3][7:0]) * dt) >>> 4);
      v = ((longint'({~p[4][11], p[4][10:0]}) * v) >>> 9);
      v = v + $signed(p[5][11:0]);
      v = (v < 0) ? 0 : (v > 4095) ? 4095 : v;
      if (p[3][8]) v = 4095 - v;
      v = (v < p[7][10:0]) ? p[7][10:0] : v;
      v = (v > 2048 + p[6][10:0]) ? 2048 + p[6][10:0] : v;
      return 12'(v);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a < 8'h20) p[a[4:2]] = d[15:0];
   endtask
   task automatic smp(input int y, input int t, input int ex);
      logic [11:0] e;
      e = (ex < 0) ? mdl(y, t) : 12'(ex);
      {adc_valid, adc_sample, temp_c} <= {1'b1, 16'(y), 9'(t)};
      @(posedge clk);
      adc_valid <= 1'b0;
      repeat (5) @(posedge clk);
      chk(duty_cycle, e);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      complete_run();
   end
   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {adc_valid, adc_sample, temp_c} = '0;
      {uv_lo, uv_hi, ov_hi, ov_lo} = 4'b0101;
      num_errors = 0;
      samples_checked = 0;
      p = lh_pkg::RST_WORD;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, {16'h0000, lh_pkg::RST_WORD[i]});
      end
      foreach (ys[i]) smp(ys[i] * 7, 25, -1);
      chk(host_frames, 3);
      chk(host_duty, mdl(6300, 25));
      $display("test defaults done");
      wr(8'h00, 32'hA418);
      wr(8'h04, 32'h1F0);
      wr(8'h08, 32'h030);
      wr(8'h0C, 32'h050);
      foreach (ts[i]) smp(300, ts[i], -1);
      $display("test temperature done");
      foreach (ca[i]) begin
         wr(ca[i], cd[i]);
         foreach (ys[j]) smp(ys[j], 25, -1);
      end
      wr(8'h28, 32'hFFF);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, mdl(900, 25));
      apb(1'b0, 8'h2C, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      $display("test output shaping done");
      {uv_lo, uv_hi} <= 2'b10;
      repeat (8) @(posedge clk);
      chk(duty_cycle, 12'hFFF);
      {ov_hi, ov_lo} <= 2'b10;
      repeat (8) @(posedge clk);
      chk(duty_cycle, 12'h000);
      {ov_hi, ov_lo} <= 2'b01;
      repeat (8) @(posedge clk);
      {uv_lo, uv_hi} <= 2'b01;
      repeat (10) @(posedge clk);
      chk(duty_cycle, 12'hFFF);
      repeat (30) @(posedge clk);
      smp(100, 25, -1);
      {ov_hi, ov_lo} <= 2'b10;
      repeat (2) @(posedge clk);
      ov_hi <= 1'b0;
      repeat (8) @(posedge clk);
      smp(100, 25, 0);
      ov_lo <= 1'b1;
      repeat (6) @(posedge clk);
      smp(100, 25, -1);
      $display("test supply done");
      wr(8'h20, 32'h00000004);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'hA418);
      smp(300, 85, -1);
      wr(8'h20, 32'h03000006);
      repeat (3) @(posedge clk);
      chk(duty_cycle, 12'h000);
      smp(300, 85, 0);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h00000018);
      $display("test memory done");
      complete_run();
   end
endmodule
`default_nettype wire
